// ---- bssc_regs.vh ----
// constants and cycle codes for the burst synchronous static memory core
// Notes on behaviour
// - inputs but output enable and reset are taken at each rising edge
// - array holds 65,536 words of 18 bits, 16-bit word address
// - a 2-bit counter, gated by advance, makes addresses after a start
// - writes are timed inside, started by the edge that samples the write
// - lower enable stores bits 0-8, upper enable bits 9-17, other byte kept
// - select high with either strobe low deselects, no address used
// - select low and processor strobe low loads address, starts read burst
// - controller strobe low, a write enable low: load address, write burst
// - controller strobe, no write enable low: load address, read burst
// - both strobes high, advance low: next burst address, read or write
// - both strobes and advance high: hold address, repeat read or write
// - read drives the bus while output enable is low, else high-impedance
// - write keeps outputs off and takes input data whatever output enable is
// - deselected keeps the bus high-impedance whatever output enable is
// - outputs high-impedance from power-up until a read is enabled
`ifndef BSSC_REGS_VH
`define BSSC_REGS_VH

`define BSSC_ADDR_W 16
`define BSSC_DATA_W 18
`define BSSC_LANE_W 9
`define BSSC_DEPTH 65536
`define BSSC_BURST_W 2

// cycle codes taken at one edge
`define BSSC_OP_W 3
`define BSSC_OP_IDLE 3'h0
`define BSSC_OP_DESEL 3'h1
`define BSSC_OP_RD_EXT 3'h2
`define BSSC_OP_WR_EXT 3'h3
`define BSSC_OP_RD_NEXT 3'h4
`define BSSC_OP_WR_NEXT 3'h5
`define BSSC_OP_RD_CUR 3'h6
`define BSSC_OP_WR_CUR 3'h7

// reset values
`define BSSC_RST_ADDR 16'h0000
`define BSSC_RST_COUNT 2'h0

`endif

// ---- bssc_array.v ----
// word array with two byte lanes and a combinational read port
`timescale 1ns/1ps
`include "bssc_regs.vh"
module bssc_array #(
  parameter ADDR_W = `BSSC_ADDR_W,
  parameter DATA_W = `BSSC_DATA_W,
  parameter LANE_W = `BSSC_LANE_W,
  parameter DEPTH = `BSSC_DEPTH
) (
  // clock
  input wire clk_in,
  // write port
  input wire wr_lo_in,
  input wire wr_hi_in,
  input wire [ADDR_W-1:0] wr_addr_in,
  input wire [DATA_W-1:0] wr_data_in,
  // read port
  input wire [ADDR_W-1:0] rd_addr_in,
  output wire [DATA_W-1:0] rd_data_out
);

  // no reset: contents are undefined at power-up, as in a real array
  reg [DATA_W-1:0] mem_q [0:DEPTH-1];

  always @(posedge clk_in) begin
    if (wr_lo_in) begin
      mem_q[wr_addr_in][LANE_W-1:0] <= wr_data_in[LANE_W-1:0];
    end
    if (wr_hi_in) begin
      mem_q[wr_addr_in][DATA_W-1:LANE_W] <= wr_data_in[DATA_W-1:LANE_W];
    end
  end

  assign rd_data_out = mem_q[rd_addr_in];

endmodule

// ---- bssc_core.v ----
// burst synchronous static memory core: cycle decode, burst counter, data port
`timescale 1ns/1ps
`include "bssc_regs.vh"
module bssc_core #(
  parameter ADDR_W = `BSSC_ADDR_W,
  parameter DATA_W = `BSSC_DATA_W,
  parameter LANE_W = `BSSC_LANE_W,
  parameter DEPTH = `BSSC_DEPTH
) (
  // clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // address and cycle controls, synchronous to core_clk_in
  input wire [ADDR_W-1:0] word_addr_in,
  input wire cs_n_in,
  input wire processor_addr_strobe_n_in,
  input wire controller_addr_strobe_n_in,
  input wire burst_advance_n_in,
  input wire lower_byte_write_n_in,
  input wire upper_byte_write_n_in,
  // asynchronous output enable
  input wire output_on_n_in,
  // data bus, split into its three signals
  input wire [DATA_W-1:0] data_bus_in,
  output wire [DATA_W-1:0] data_bus_out,
  output wire data_bus_oe_out
);

  // decode of one edge's controls into a cycle code
  function [`BSSC_OP_W-1:0] bssc_decode;
    input cs_n;
    input ps_n;
    input cs_strobe_n;
    input adv_n;
    input lw_n;
    input uw_n;
    reg wr;
    begin
      wr = ~lw_n | ~uw_n;
      if (cs_n & (~ps_n | ~cs_strobe_n)) begin
        bssc_decode = `BSSC_OP_DESEL;
      end else if (~ps_n) begin
        bssc_decode = `BSSC_OP_RD_EXT;
      end else if (~cs_strobe_n & wr) begin
        bssc_decode = `BSSC_OP_WR_EXT;
      end else if (~cs_strobe_n) begin
        bssc_decode = `BSSC_OP_RD_EXT;
      end else if (~adv_n) begin
        bssc_decode = wr ? `BSSC_OP_WR_NEXT : `BSSC_OP_RD_NEXT;
      end else begin
        bssc_decode = wr ? `BSSC_OP_WR_CUR : `BSSC_OP_RD_CUR;
      end
    end
  endfunction

  // control state
  reg [ADDR_W-1:0] base_q;
  reg [ADDR_W-1:0] base_d;
  reg [`BSSC_BURST_W-1:0] count_q;
  reg [`BSSC_BURST_W-1:0] count_d;
  reg active_q;
  reg active_d;
  reg rd_q;
  reg rd_d;

  // per-edge decode
  wire [`BSSC_OP_W-1:0] op;
  reg [ADDR_W-1:0] eff_addr;
  reg wr_cycle;
  reg [`BSSC_BURST_W-1:0] step;

  // the edge itself is the input register: every control is sampled here
  assign op = bssc_decode(cs_n_in, processor_addr_strobe_n_in,
    controller_addr_strobe_n_in, burst_advance_n_in,
    lower_byte_write_n_in, upper_byte_write_n_in);

  always @* begin
    base_d = base_q;
    count_d = count_q;
    active_d = active_q;
    rd_d = 1'b0;
    wr_cycle = 1'b0;
    step = count_q + 2'h1;
    eff_addr = {base_q[ADDR_W-1:`BSSC_BURST_W],
      base_q[`BSSC_BURST_W-1:0] ^ count_q};
    case (op)
      `BSSC_OP_DESEL: begin
        active_d = 1'b0;
      end
      `BSSC_OP_RD_EXT: begin
        base_d = word_addr_in;
        count_d = `BSSC_RST_COUNT;
        active_d = 1'b1;
        rd_d = 1'b1;
        eff_addr = word_addr_in;
      end
      `BSSC_OP_WR_EXT: begin
        base_d = word_addr_in;
        count_d = `BSSC_RST_COUNT;
        active_d = 1'b1;
        wr_cycle = 1'b1;
        eff_addr = word_addr_in;
      end
      `BSSC_OP_RD_NEXT, `BSSC_OP_WR_NEXT: begin
        if (active_q) begin
          count_d = step;
          eff_addr = {base_q[ADDR_W-1:`BSSC_BURST_W],
            base_q[`BSSC_BURST_W-1:0] ^ step};
          wr_cycle = (op == `BSSC_OP_WR_NEXT);
          rd_d = (op == `BSSC_OP_RD_NEXT);
        end
      end
      `BSSC_OP_RD_CUR, `BSSC_OP_WR_CUR: begin
        if (active_q) begin
          wr_cycle = (op == `BSSC_OP_WR_CUR);
          rd_d = (op == `BSSC_OP_RD_CUR);
        end
      end
      default: begin
        active_d = active_q;
      end
    endcase
  end

  // rd_addr_q is where the current read points; it follows eff_addr
  reg [ADDR_W-1:0] rd_addr_q;

  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      base_q <= `BSSC_RST_ADDR;
      count_q <= `BSSC_RST_COUNT;
      active_q <= 1'b0;
      rd_q <= 1'b0;
      rd_addr_q <= `BSSC_RST_ADDR;
    end else begin
      base_q <= base_d;
      count_q <= count_d;
      active_q <= active_d;
      rd_q <= rd_d;
      rd_addr_q <= eff_addr;
    end
  end

  // write goes into the array at the sampling edge, no outside pulse needed
  bssc_array #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .LANE_W(LANE_W),
    .DEPTH(DEPTH)
  ) u_array (
    .clk_in(core_clk_in),
    .wr_lo_in(wr_cycle & ~lower_byte_write_n_in),
    .wr_hi_in(wr_cycle & ~upper_byte_write_n_in),
    .wr_addr_in(eff_addr),
    .wr_data_in(data_bus_in),
    .rd_addr_in(rd_addr_q),
    .rd_data_out(data_bus_out)
  );

  // output enable is a gate, not a flop, so it follows the pin at once;
  // write and deselect cycles clear rd_q, keeping the bus off
  assign data_bus_oe_out = rd_q & ~output_on_n_in;

endmodule

// ---- bssc_core_properties.sv ----
// assertions on the burst memory core ports
`timescale 1ns/1ps
module bssc_core_props #(parameter DATA_W = 18) (
  // clock, reset and controls
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire cs_n_in,
  input wire processor_addr_strobe_n_in,
  input wire controller_addr_strobe_n_in,
  input wire burst_advance_n_in,
  input wire lower_byte_write_n_in,
  input wire upper_byte_write_n_in,
  input wire output_on_n_in,
  // data bus outputs
  input wire [DATA_W-1:0] data_bus_out,
  input wire data_bus_oe_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire p = !processor_addr_strobe_n_in, s = !controller_addr_strobe_n_in;
  wire w = !lower_byte_write_n_in | !upper_byte_write_n_in;
  wire e = !cs_n_in, oe = data_bus_oe_out, gn = output_on_n_in;
  wire h = !p && !s, cst = e && !p && s;
  a_desel_hiz: assert property (!e && (p || s) |=> !oe)
    else $error("bus driven after deselect");
  a_proc_read: assert property (e && p |=> gn || oe)
    else $error("read start not driven");
  a_wstart_hiz: assert property (cst && w |=> !oe)
    else $error("bus driven in write start");
  a_cstart_read: assert property (cst && !w |=> gn || oe)
    else $error("strobe read not driven");
  a_wcont_hiz: assert property (h && w |=> !oe)
    else $error("bus driven in burst write");
  a_hold_data: assert property (h && burst_advance_n_in && !w && oe
    |=> $stable(data_bus_out))
    else $error("suspended read word moved");
  a_oe_gate: assert property (gn |-> !oe)
    else $error("bus driven with enable off");
  a_reset_hiz: assert property (@(posedge core_clk_in)
    disable iff (1'b0) sys_rst_in |-> !oe)
    else $error("bus driven in reset");
  cover property (e && p ##1 oe);
  cover property (cst && w);
  cover property (h && !burst_advance_n_in && oe);
  cover property (h && burst_advance_n_in && !w && oe);
endmodule
bind bssc_core bssc_core_props #(.DATA_W(DATA_W)) bssc_core_props_i (
  .core_clk_in, .sys_rst_in, .cs_n_in, .processor_addr_strobe_n_in,
  .controller_addr_strobe_n_in, .burst_advance_n_in, .output_on_n_in,
  .lower_byte_write_n_in, .upper_byte_write_n_in, .data_bus_out,
  .data_bus_oe_out);

// ---- bssc_host_model.sv ----
// processor-side model driving one burst cycle per clock
`timescale 1ns/1ps
module bssc_host_model (
  // clock
  input wire clk_in,
  // cycle controls, address, write data, output enable
  output reg [5:0] ctl_out,
  output reg [15:0] addr_out,
  output reg [17:0] wdata_out,
  output reg oe_n_out
);
  initial {ctl_out, addr_out, wdata_out, oe_n_out} = {6'h3F, 34'h0, 1'b1};
  // idle data flips so stale write data never looks driven
  task cyc(input [5:0] c, input [15:0] a, input [17:0] d, input g);
    ctl_out = c;
    addr_out = a;
    wdata_out = &c[1:0] ? ~wdata_out : d;
    oe_n_out = g;
    @(posedge clk_in);
    #1;
  endtask
endmodule

// ---- bssc_core_tb_top.sv ----
// bench: burst write, read, byte-lane and deselect cycles
`timescale 1ns/1ps
module bssc_core_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  wire [5:0] c;
  wire [15:0] a;
  wire [17:0] h, q;
  wire g, oe;
  int n_errors = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  bssc_host_model bssc_host_model_i (.clk_in(clk), .ctl_out(c),
    .addr_out(a), .wdata_out(h), .oe_n_out(g));
  bssc_core bssc_core_i (.core_clk_in(clk), .sys_rst_in(rst),
    .word_addr_in(a), .cs_n_in(c[5]), .processor_addr_strobe_n_in(c[4]),
    .controller_addr_strobe_n_in(c[3]), .burst_advance_n_in(c[2]),
    .lower_byte_write_n_in(c[1]), .upper_byte_write_n_in(c[0]),
    .output_on_n_in(g), .data_bus_in(oe ? q : h), .data_bus_out(q),
    .data_bus_oe_out(oe));
  function [17:0] pat(input [15:0] x); return {2'h2, x}; endfunction
  task chk(input string n, input [17:0] e, input [17:0] s);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // k bits: select, proc strobe, ctrl strobe, advance, lower, upper
  task cy(input [5:0] k, input [15:0] x, input [17:0] d, input o);
    bssc_host_model_i.cyc(k, x, d, o);
  endtask
  task t_wr_burst;
    cy(6'h14, 16'h12, pat(16'h12), 1'b0);
    for (int k = 1; k < 4; k++)
      cy(6'h38, 16'h0, pat(16'h12 ^ 16'(k)), 1'b0);
    chk("oe", 0, oe);
  endtask
  task t_rd_burst;
    cy(6'h0F, 16'h11, 0, 1'b0);
    chk("rd", pat(16'h11), q);
    for (int k = 1; k < 5; k++) begin
      cy(6'h3B, 16'h0, 0, 1'b0);
      chk("rd", pat(16'h11 ^ 16'(k % 4)), q);
      chk("oe", 1, oe);
    end
    // wait state with the bus still enabled: word must hold
    cy(6'h3F, 16'h0, 0, 1'b0);
    chk("rd", pat(16'h11), q);
    chk("oe", 1, oe);
    cy(6'h3F, 16'h0, 0, 1'b1);
    chk("rd", pat(16'h11), q);
    chk("oe", 0, oe);
  endtask
  task t_lanes;
    cy(6'h15, 16'h10, 18'h3FFFF, 1'b1);
    cy(6'h3E, 16'h0, 18'h0, 1'b1);
    cy(6'h39, 16'h0, 18'h3FFFF, 1'b1);
    cy(6'h17, 16'h10, 0, 1'b0);
    chk("lo", 18'h001FF, q);
    cy(6'h3B, 16'h0, 0, 1'b0);
    chk("hi", pat(16'h11) | 18'h001FF, q);
  endtask
  task t_desel;
    cy(6'h2F, 16'h12, 0, 1'b0);
    chk("oe", 0, oe);
    cy(6'h38, 16'h0, 18'h0, 1'b0);
    // a continue let through after deselect would clear word 12
    cy(6'h0F, 16'h12, 0, 1'b0);
    chk("rd", pat(16'h12), q);
    cy(6'h37, 16'h0, 0, 1'b0);
    chk("oe", 0, oe);
  endtask
  // reset mid-burst: bus off at once, and no burst left to continue
  task t_reset;
    cy(6'h0F, 16'h12, 0, 1'b0);
    chk("oe", 1, oe);
    rst = 1'b1;
    #1 chk("oe", 0, oe);
    @(posedge clk);
    #1 rst = 1'b0;
    cy(6'h3B, 16'h0, 0, 1'b0);
    chk("oe", 0, oe);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    chk("oe", 0, oe);
    #1 rst = 1'b0;
    t_wr_burst();
    t_rd_burst();
    t_lanes();
    t_desel();
    t_reset();
    test_done();
  end
  initial begin
    #20000 n_errors++;
    test_done();
  end
  task test_done;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
endmodule
